//--- hdl/serial_gpio_regs.svh
`ifndef SERIAL_GPIO_REGS_SVH
`define SERIAL_GPIO_REGS_SVH

// ****************************************************************
// register byte offsets (apb 32-bit words; pin vectors span four words, port config 32)
// ****************************************************************
`define OFS_INPUT_DATA    8'h00
`define OFS_GENERAL_CFG   8'h10
`define OFS_PORT_IRQ_EN   8'h14
`define OFS_LOS_GPIO_SEL  8'h18
`define OFS_UNMAPPED      8'h1C
`define OFS_POLARITY      8'h20
`define OFS_RAW_IRQ       8'h30
`define OFS_TRIG_LOW      8'h40
`define OFS_TRIG_HIGH     8'h50
`define OFS_STICKY        8'h60
`define OFS_IDENTITY      8'h70
`define OFS_PORT_CFG      8'h80

// ****************************************************************
// field positions
// ****************************************************************
`define GCFG_BMODE0_LSB   0
`define GCFG_BMODE1_LSB   2
`define GCFG_BLINK_CLR    4
`define GCFG_POS_EN_LSB   8
`define PCFG_SRC_LSB      0
`define PCFG_PWM_LSB      12
`define PCFG_POL_LSB      20
`define PCFG_W            24

// ****************************************************************
// sizes and reset values
// ****************************************************************
`define NUM_PORTS         32
`define NUM_POS           4
`define NUM_PINS          128
`define ACT_PORTS         11
`define BURST_TOGGLE_CODE 2'h3
`define RST_WORD          32'h0000_0000

// ****************************************************************
// timing
// ****************************************************************
`define CLK_HZ            10000000
`define BLINK_FAST_HZ     20
`define ACT_STRETCH_MS    100
`define CNT_W             20
`define BLINK_HALF_CNT    (`CLK_HZ / (2 * `BLINK_FAST_HZ))
`define ACT_STRETCH_CNT   ((`CLK_HZ / 1000) * `ACT_STRETCH_MS)

`endif

//--- hdl/serial_gpio_pkg.sv
`include "serial_gpio_regs.svh"

package serial_gpio_pkg;

  // per-pin output source codes
  typedef enum logic [2:0] {
    SRC_STATIC0,
    SRC_STATIC1,
    SRC_BLINK0,
    SRC_BLINK1,
    SRC_ACT_BLINK0,
    SRC_ACT_BLINK1,
    SRC_ACTINV_BLINK0,
    SRC_ACTINV_BLINK1
  } bit_source_type;

  // whole block state, registered in one process
  typedef struct packed {
    logic [`NUM_PINS-1:0]                     in_data;
    logic [`NUM_PINS-1:0]                     raw;
    logic [`NUM_PINS-1:0]                     sticky;
    logic [`NUM_PINS-1:0]                     ident;
    logic [`NUM_PINS-1:0]                     pol;
    logic [`NUM_PINS-1:0]                     trig_low;
    logic [`NUM_PINS-1:0]                     trig_high;
    logic [`NUM_PORTS-1:0]                    port_irq_en;
    logic [`NUM_POS-1:0]                      pos_irq_en;
    logic [1:0]                               bmode0;
    logic [1:0]                               bmode1;
    logic [`ACT_PORTS-1:0]                    los_sel;
    logic [`NUM_PORTS-1:0][`PCFG_W-1:0]       port_cfg;
    logic [`CNT_W-1:0]                        presc;
    logic [3:0]                               blink_div;
    logic                                     burst_tgl;
    logic [`ACT_PORTS-1:0][`CNT_W-1:0]        env_cnt;
    logic [`ACT_PORTS-1:0]                    sync1;
    logic [`ACT_PORTS-1:0]                    sync2;
    logic [`ACT_PORTS-1:0]                    los;
    logic [`NUM_PINS-1:0]                     pins;
    logic                                     irq;
    logic                                     pready;
    logic                                     pslverr;
    logic [31:0]                              prdata;
  } state_type;

endpackage

//--- hdl/serial_gpio_modes_intr.sv
`timescale 1ns/1ps
`include "serial_gpio_regs.svh"

// What this block does
// RULE1: every pin picks static, blink or activity mode, plus pwm and inversion
// RULE2: static mode drives a software chosen constant zero or one
// RULE3: two independent blink generators, each pin selects one of them
// RULE4: generator zero rate codes give 20, 10, 5 and 2.5 Hz
// RULE5: generator one codes give 20, 10, 5 Hz; code 3 toggles per burst
// RULE6: software blink clear zeroes the blink counter for phase alignment
// RULE7: activity mode blinks while the envelope is up, off otherwise
// RULE8: each rx or tx pulse stretches the envelope by 100 ms
// RULE9: ports 0 to 10 map to port modules 0 to 10, rest unattached
// RULE10: source selection also picks the inverted activity variant
// RULE11: interrupts come from sampled inputs and the line is level sensitive
// RULE12: per-port 32-bit enable combined with 4-bit per-position enable
// RULE13: raw vector is sampled input after polarity inversion, follows input
// RULE14: two trigger vectors pick level, any edge, falling or rising
// RULE15: sticky bit sets on trigger, clears on write one, zero writes ignored
// RULE16: identity is sticky masked by both enables, tracks all changes
// RULE17: one interrupt line high while any identity bit is set
// RULE18: position 0 of each port goes to that port module's loss input
// RULE19: forwarded loss value uses the same polarity inversion as interrupts
// RULE20: when the gpio loss source is chosen the serial value is ignored
// RULE21: port module enables its own loss input before it takes effect
// RULE22: 128 pins as 32 ports of four positions
// RULE23: sampled serial inputs are readable by software
// RULE24: blink waves come from a free running counter at fifty percent duty
// RULE25: pwm combines with the mode output before polarity inversion
module serial_gpio_modes_intr #(
  parameter logic [`CNT_W-1:0] BLINK_HALF_CYCLES  = `CNT_W'(`BLINK_HALF_CNT),
  parameter logic [`CNT_W-1:0] ACT_STRETCH_CYCLES = `CNT_W'(`ACT_STRETCH_CNT)
) (
  // clock, reset, enable
  input  wire logic                    sys_clk_in,
  input  wire logic                    rst_in,
  input  wire logic                    ce_in,
  // apb slave
  input  wire logic                    psel_in,
  input  wire logic                    penable_in,
  input  wire logic                    pwrite_in,
  input  wire logic [7:0]              paddr_in,
  input  wire logic [31:0]             pwdata_in,
  output logic      [31:0]             prdata_out,
  output logic                         pready_out,
  output logic                         pslverr_out,
  // shift engine side, same clock
  input  wire logic [`NUM_PINS-1:0]    in_sample_in,
  input  wire logic                    burst_done_in,
  output logic      [`NUM_PINS-1:0]    pin_value_out,
  // pwm waveforms and port module activity, same clock
  input  wire logic [2:0]              pwm_src_in,
  input  wire logic [`ACT_PORTS-1:0]   rx_act_in,
  input  wire logic [`ACT_PORTS-1:0]   tx_act_in,
  // loss of signal
  input  wire logic [`ACT_PORTS-1:0]   gpio_los_in,
  output logic      [`ACT_PORTS-1:0]   los_out,
  // interrupt to main controller
  output logic                         irq_out
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  serial_gpio_pkg::state_type s;
  serial_gpio_pkg::state_type n;

  logic                      wr;
  logic                      setup;
  logic [6:0]                wbase;
  logic [`NUM_PINS-1:0]      w1c;
  logic                      blink_clr;
  logic                      blink0;
  logic                      blink1;
  logic [`NUM_PINS-1:0]      cond;
  logic [`NUM_PINS-1:0]      mask;
  logic [31:0]               rd;

  // one 32-bit slice of a pin vector
  function automatic logic [31:0] word_of(input logic [`NUM_PINS-1:0] v,
                                          input logic [1:0]           w);
    word_of = v[{w, 5'h00} +: 32];
  endfunction

  // selected blink wave: code picks a divider tap
  function automatic logic tap_of(input logic [3:0] div, input logic [1:0] code);
    tap_of = div[code];
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [`PCFG_W-1:0]              cfg;
    serial_gpio_pkg::bit_source_type src;
    logic [1:0]                      pwm_sel;
    logic                            pwm_wave;
    logic                            env;
    logic                            bl;
    logic                            v;
    cfg      = '0;
    src      = serial_gpio_pkg::SRC_STATIC0;
    pwm_sel  = 2'h0;
    pwm_wave = 1'b1;
    env      = 1'b0;
    bl       = 1'b0;
    v        = 1'b0;
    n        = s;

    // apb phases: registered answer, no wait states beyond the access cycle
    setup     = psel_in & ~penable_in;
    wr        = psel_in & penable_in & pwrite_in & s.pready;
    wbase     = {paddr_in[3:2], 5'h00};
    w1c       = '0;
    blink_clr = 1'b0;

    // read data captured at setup so prdata comes from a flop
    rd = `RST_WORD;
    unique case (paddr_in[7:4])
      4'h0: rd = word_of(s.in_data, paddr_in[3:2]); // RULE23
      4'h1: begin
        unique case (paddr_in[3:2])
          2'h0: begin
            rd[`GCFG_BMODE0_LSB +: 2]       = s.bmode0;
            rd[`GCFG_BMODE1_LSB +: 2]       = s.bmode1;
            rd[`GCFG_POS_EN_LSB +: `NUM_POS] = s.pos_irq_en;
          end
          2'h1: rd = s.port_irq_en;
          2'h2: rd[`ACT_PORTS-1:0] = s.los_sel;
          2'h3: rd = `RST_WORD;
        endcase
      end
      4'h2: rd = word_of(s.pol, paddr_in[3:2]);
      4'h3: rd = word_of(s.raw, paddr_in[3:2]);
      4'h4: rd = word_of(s.trig_low, paddr_in[3:2]);
      4'h5: rd = word_of(s.trig_high, paddr_in[3:2]);
      4'h6: rd = word_of(s.sticky, paddr_in[3:2]);
      4'h7: rd = word_of(s.ident, paddr_in[3:2]);
      default: rd[`PCFG_W-1:0] = s.port_cfg[paddr_in[6:2]];
    endcase

    n.pready  = setup;
    n.pslverr = setup & (paddr_in == `OFS_UNMAPPED);
    if (setup) begin
      n.prdata = rd;
    end

    // register writes, effective at the access edge with pready high
    if (wr) begin
      unique case (paddr_in[7:4])
        4'h1: begin
          unique case (paddr_in[3:2])
            2'h0: begin
              n.bmode0     = pwdata_in[`GCFG_BMODE0_LSB +: 2];
              n.bmode1     = pwdata_in[`GCFG_BMODE1_LSB +: 2];
              n.pos_irq_en = pwdata_in[`GCFG_POS_EN_LSB +: `NUM_POS];
              blink_clr    = pwdata_in[`GCFG_BLINK_CLR]; // RULE6
            end
            2'h1: n.port_irq_en = pwdata_in; // RULE12
            2'h2: n.los_sel = pwdata_in[`ACT_PORTS-1:0];
            2'h3: n.los_sel = s.los_sel;
          endcase
        end
        4'h2: n.pol[wbase +: 32]       = pwdata_in;
        4'h4: n.trig_low[wbase +: 32]  = pwdata_in;
        4'h5: n.trig_high[wbase +: 32] = pwdata_in;
        4'h6: w1c[wbase +: 32]         = pwdata_in; // RULE15
        4'h0, 4'h3, 4'h7: n.pol = s.pol;
        default: n.port_cfg[paddr_in[6:2]] = pwdata_in[`PCFG_W-1:0];
      endcase
    end

    // ****************************************************************
    // blink generators
    // ****************************************************************
    // prescaler marks half periods of the fastest rate; divider taps halve it
    if (blink_clr) begin
      n.presc     = '0; // RULE6
      n.blink_div = 4'h0;
      n.burst_tgl = 1'b0;
    end else begin
      if (s.presc >= BLINK_HALF_CYCLES - `CNT_W'(1)) begin
        n.presc     = '0;
        n.blink_div = s.blink_div + 4'h1; // RULE24
      end else begin
        n.presc = s.presc + `CNT_W'(1);
      end
      if (burst_done_in) begin
        n.burst_tgl = ~s.burst_tgl; // RULE5
      end
    end
    blink0 = tap_of(s.blink_div, s.bmode0); // RULE4
    blink1 = (s.bmode1 == `BURST_TOGGLE_CODE) ? s.burst_tgl
                                              : tap_of(s.blink_div, s.bmode1); // RULE3

    // ****************************************************************
    // activity envelopes
    // ****************************************************************
    // a new pulse reloads the full stretch, so activity keeps it alive
    for (int p = 0; p < `ACT_PORTS; p++) begin
      if (rx_act_in[p] | tx_act_in[p]) begin
        n.env_cnt[p] = ACT_STRETCH_CYCLES; // RULE8
      end else if (s.env_cnt[p] != '0) begin
        n.env_cnt[p] = s.env_cnt[p] - `CNT_W'(1);
      end
    end

    // ****************************************************************
    // per-pin outputs
    // ****************************************************************
    for (int p = 0; p < `NUM_PORTS; p++) begin
      cfg = s.port_cfg[p];
      env = (p < `ACT_PORTS) ? (s.env_cnt[p] != '0) : 1'b0; // RULE9
      for (int q = 0; q < `NUM_POS; q++) begin
        src     = serial_gpio_pkg::bit_source_type'(cfg[`PCFG_SRC_LSB + 3*q +: 3]);
        pwm_sel = cfg[`PCFG_PWM_LSB + 2*q +: 2];
        bl      = src[0] ? blink1 : blink0;
        unique case (src)
          serial_gpio_pkg::SRC_STATIC0:       v = 1'b0; // RULE2
          serial_gpio_pkg::SRC_STATIC1:       v = 1'b1;
          serial_gpio_pkg::SRC_BLINK0:        v = bl;
          serial_gpio_pkg::SRC_BLINK1:        v = bl;
          serial_gpio_pkg::SRC_ACT_BLINK0:    v = bl & env; // RULE7
          serial_gpio_pkg::SRC_ACT_BLINK1:    v = bl & env;
          serial_gpio_pkg::SRC_ACTINV_BLINK0: v = bl & ~env; // RULE10
          serial_gpio_pkg::SRC_ACTINV_BLINK1: v = bl & ~env;
        endcase
        pwm_wave = (pwm_sel == 2'h0) ? 1'b1 : pwm_src_in[pwm_sel - 2'h1];
        n.pins[4*p + q] = (v & pwm_wave) ^ cfg[`PCFG_POL_LSB + q]; // RULE25 RULE1
      end
    end

    // ****************************************************************
    // interrupts
    // ****************************************************************
    n.in_data = in_sample_in; // RULE22
    n.raw     = in_sample_in ^ s.pol; // RULE13
    // trigger codes {high,low}: 0 level, 1 any edge, 2 falling, 3 rising
    cond = (~s.trig_high & ~s.trig_low & n.raw)
         | (~s.trig_high &  s.trig_low & (n.raw ^ s.raw))
         | ( s.trig_high & ~s.trig_low & ~n.raw & s.raw)
         | ( s.trig_high &  s.trig_low & n.raw & ~s.raw); // RULE14 RULE11
    // a new event wins over a clear in the same cycle
    n.sticky = (s.sticky & ~w1c) | cond; // RULE15
    for (int p = 0; p < `NUM_PORTS; p++) begin
      mask[4*p +: 4] = {`NUM_POS{n.port_irq_en[p]}} & n.pos_irq_en; // RULE12
    end
    n.ident = n.sticky & mask; // RULE16
    n.irq   = |n.ident; // RULE17

    // ****************************************************************
    // loss of signal forwarding
    // ****************************************************************
    // only sync2 is read, sync1 stays a pure metastability stage
    n.sync1 = gpio_los_in;
    n.sync2 = s.sync1;
    for (int p = 0; p < `ACT_PORTS; p++) begin
      n.los[p] = s.los_sel[p] ? s.sync2[p] : s.raw[4*p]; // RULE18 RULE19 RULE20
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      s <= '0;
    end else if (ce_in) begin
      s <= n;
    end
  end

  // outputs straight from the state register
  assign prdata_out    = s.prdata;
  assign pready_out    = s.pready;
  assign pslverr_out   = s.pslverr;
  assign pin_value_out = s.pins;
  assign los_out       = s.los;
  assign irq_out       = s.irq;

endmodule

//--- bench/serial_gpio_checker.sv
`timescale 1ns/1ps
`include "serial_gpio_regs.svh"

// ****************
// port checker
// ****************
module serial_gpio_checker (
  // clock and reset
  input wire logic                 sys_clk_in,
  input wire logic                 rst_in,
  input wire logic                 ce_in,
  // apb
  input wire logic                 psel_in,
  input wire logic                 penable_in,
  input wire logic                 pwrite_in,
  input wire logic [7:0]           paddr_in,
  input wire logic [31:0]          prdata_out,
  input wire logic                 pready_out,
  input wire logic                 pslverr_out,
  // inputs and interrupt
  input wire logic [`NUM_PINS-1:0] in_sample_in,
  input wire logic                 burst_done_in,
  input wire logic                 irq_out
);
  logic setup;
  logic wr_acc;

  // setup edge and completed write as seen at the pins
  assign setup  = ce_in && psel_in && !penable_in;
  assign wr_acc = psel_in && penable_in && pwrite_in && pready_out;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  a_ready_setup: assert property (setup |=> pready_out)
    else $error("ready missing after setup");
  a_ready_single: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  a_err_unmapped: assert property (setup && paddr_in[7:2] == 6'h07 |=>
    pslverr_out && prdata_out == 32'h0) else $error("hole not refused");
  a_err_mapped: assert property (setup && paddr_in[7:2] != 6'h07 |=> !pslverr_out)
    else $error("mapped word refused");
  a_rdata_hold: assert property (!setup |=> $stable(prdata_out))
    else $error("read data moved outside setup");
  // only a write can clear the line: sticky bits never fall by themselves
  a_irq_holds: assert property (irq_out && !wr_acc |=> irq_out)
    else $error("interrupt dropped without write");
  a_irq_quiet: assert property (!irq_out && !wr_acc && $stable(in_sample_in)
    |=> !irq_out) else $error("interrupt without cause");

  c_irq_rise: cover property ($rose(irq_out));
  c_err: cover property (pslverr_out);
  c_burst: cover property (burst_done_in);
endmodule

bind serial_gpio_modes_intr serial_gpio_checker chk (.sys_clk_in, .rst_in, .ce_in,
  .psel_in, .penable_in, .pwrite_in, .paddr_in, .prdata_out, .pready_out, .pslverr_out,
  .in_sample_in, .burst_done_in, .irq_out);

//--- bench/serial_chain_model.sv
`timescale 1ns/1ps
`include "serial_gpio_regs.svh"

// ****************
// shift chain, leds and port modules
// ****************
module serial_chain_model (
  // clock and reset
  input  wire logic                  sys_clk_in,
  input  wire logic                  rst_in,
  // bench request
  input  wire logic                  shift_req_in,
  input  wire logic [`NUM_PINS-1:0]  chain_in,
  input  wire logic [`ACT_PORTS-1:0] los_ena_in,
  // block side
  output logic      [`NUM_PINS-1:0]  in_sample_out,
  output logic                       burst_done_out,
  input  wire logic [`NUM_PINS-1:0]  pin_value_in,
  input  wire logic [`ACT_PORTS-1:0] los_in,
  // what leds and port modules show
  output logic      [`NUM_PINS-1:0]  led_out,
  output logic      [`ACT_PORTS-1:0] los_seen_out
);
  logic [3:0] cnt;

  // a burst takes several cycles; inputs change only when it ends
  always_ff @(posedge sys_clk_in) begin
    burst_done_out <= 1'b0;
    if (rst_in) begin
      cnt <= 4'h0;
      in_sample_out <= '0;
      led_out <= '0;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1) begin
        in_sample_out <= chain_in;
        led_out <= pin_value_in;
        burst_done_out <= 1'b1;
      end
    end else if (shift_req_in) begin
      cnt <= 4'h6;
    end
  end

  // forwarded loss value counts only where the module enabled it
  assign los_seen_out = los_in & los_ena_in;
endmodule

//--- bench/tb_serial_gpio_modes_intr.sv
`timescale 1ns/1ps
`include "serial_gpio_regs.svh"

// ****************
// bench top
// ****************
module tb_serial_gpio_modes_intr;
  logic                  sys_clk_in = 1'b0;
  logic                  rst_in = 1'b1;
  logic                  psel_in = 1'b0;
  logic                  penable_in = 1'b0;
  logic                  pwrite_in = 1'b0;
  logic [7:0]            paddr_in = 8'h00;
  logic [31:0]           pwdata_in = 32'h0;
  logic [31:0]           prdata_out;
  logic                  pready_out;
  logic                  pslverr_out;
  logic [`NUM_PINS-1:0]  in_sample_in;
  logic                  burst_done_in;
  logic [`NUM_PINS-1:0]  pin_value_out;
  logic [2:0]            pwm_src_in = 3'h0;
  logic [`ACT_PORTS-1:0] rx_act_in = '0;
  logic [`ACT_PORTS-1:0] tx_act_in = '0;
  logic [`ACT_PORTS-1:0] gpio_los_in = '0;
  logic [`ACT_PORTS-1:0] los_out;
  logic                  irq_out;
  logic                  shift_req = 1'b0;
  logic [`NUM_PINS-1:0]  chain = '0;
  logic [`NUM_PINS-1:0]  led;
  logic [`ACT_PORTS-1:0] los_seen;
  logic [31:0]           q;
  logic                  err;
  int                    n_fail = 0;
  int                    check_count = 0;
  int                    t0;
  int                    t1;

  // short counts keep blink and envelope windows small
  serial_gpio_modes_intr #(.BLINK_HALF_CYCLES(`CNT_W'(4)), .ACT_STRETCH_CYCLES(`CNT_W'(20)))
    uut (.sys_clk_in, .rst_in, .ce_in(1'b1), .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .in_sample_in, .burst_done_in,
    .pin_value_out, .pwm_src_in, .rx_act_in, .tx_act_in, .gpio_los_in, .los_out, .irq_out);
  serial_chain_model chain_m (.sys_clk_in, .rst_in, .shift_req_in(shift_req), .chain_in(chain),
    .los_ena_in(11'h001), .in_sample_out(in_sample_in), .burst_done_out(burst_done_in),
    .pin_value_in(pin_value_out), .los_in(los_out), .led_out(led), .los_seen_out(los_seen));

  // clock
  always #50 sys_clk_in = ~sys_clk_in;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic stall();
    n_fail++;
    $display("[FAIL] %0t wait ran out", $time);
    print_verdict();
  endtask
  // one apb transfer; request held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    if (n >= 20) stall();
    q = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(q, exp);
  endtask
  // one burst of the chain; new inputs land when it ends
  task automatic apply_chain();
    int n;
    n = 0;
    shift_req <= 1'b1;
    @(posedge sys_clk_in);
    shift_req <= 1'b0;
    while (burst_done_in !== 1'b1 && n < 20) begin
      @(posedge sys_clk_in);
      n++;
    end
    if (n >= 20) stall();
    repeat (2) @(posedge sys_clk_in);
  endtask
  // counts changes of two pins over a window of edges
  task automatic count_tog(input int b0, input int b1, input int cyc);
    logic l0;
    logic l1;
    @(posedge sys_clk_in);
    l0 = pin_value_out[b0];
    l1 = pin_value_out[b1];
    t0 = 0;
    t1 = 0;
    repeat (cyc) begin
      @(posedge sys_clk_in);
      if (pin_value_out[b0] !== l0) t0++;
      if (pin_value_out[b1] !== l1) t1++;
      l0 = pin_value_out[b0];
      l1 = pin_value_out[b1];
    end
  endtask

  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (4) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    @(posedge sys_clk_in);
    rd(8'h14, 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    check({31'h0, err}, 32'h1);
    wr(8'h30, 32'hFFFF_FFFF);
    rd(8'h30, 32'h0);
    $display("test registers done");
    chain[31:0] = 32'hA5A5_0003;
    apply_chain();
    wr(8'h20, 32'h0000_00FF);
    rd(8'h00, 32'hA5A5_0003);
    rd(8'h30, 32'hA5A5_00FC);
    check(los_out, 32'h52);
    wr(8'h20, 32'h0);
    chain[40] = 1'b1;
    apply_chain();
    check(los_out, 32'h451);
    check(los_seen, 32'h1);
    wr(8'h18, 32'h1);
    repeat (4) @(posedge sys_clk_in);
    check(los_out, 32'h450);
    $display("test inputs and loss done");
    // level, any, falling, rising on one bit; expected per mode in bit m
    for (int m = 0; m < 4; m++) begin
      wr(8'h48, {31'h0, m[0]});
      wr(8'h58, {31'h0, m[1]});
      wr(8'h68, 32'h1);
      chain[64] = 1'b1;
      apply_chain();
      rd(8'h68, {31'h0, 4'hB >> m} & 32'h1);
      wr(8'h68, 32'h1);
      rd(8'h68, {31'h0, 4'h1 >> m} & 32'h1);
      chain[64] = 1'b0;
      apply_chain();
      rd(8'h68, {31'h0, 4'h7 >> m} & 32'h1);
    end
    $display("test triggers done");
    wr(8'h44, 32'hFFFF_FFFF);
    wr(8'h54, 32'hFFFF_FFFF);
    // bit 40 latched under level trigger earlier; clear it so word 1 starts empty
    wr(8'h64, 32'hFFFF_FFFF);
    wr(8'h14, 32'h0000_0100);
    wr(8'h10, 32'h0000_0400);
    chain[35:32] = 4'hF;
    apply_chain();
    rd(8'h64, 32'hF);
    rd(8'h74, 32'h4);
    chain[35:32] = 4'h0;
    apply_chain();
    check(irq_out, 32'h1);
    wr(8'h10, 32'h0);
    rd(8'h74, 32'h0);
    check(irq_out, 32'h0);
    wr(8'h10, 32'h0000_0400);
    wr(8'h64, 32'h0);
    rd(8'h64, 32'hF);
    check(irq_out, 32'h1);
    wr(8'h64, 32'h4);
    rd(8'h64, 32'hB);
    check(irq_out, 32'h0);
    $display("test interrupt done");
    wr(8'h80, 32'h0020_0881);
    wr(8'h84, 32'h0000_0CC0);
    apply_chain();
    check(led[1:0], 32'h3);
    for (int c = 0; c < 4; c++) begin
      wr(8'h10, {28'h0, c[1:0], c[1:0]});
      fork
        count_tog(2, 6, 64);
        repeat (3) apply_chain();
      join
      check(t0, 16 >> c);
      check(t1, (c == 3) ? 3 : 16 >> c);
    end
    wr(8'h10, 32'h0);
    for (int n = 0; n < 20 && pin_value_out[2] !== 1'b1; n++) @(posedge sys_clk_in);
    wr(8'h10, 32'h10);
    repeat (2) @(posedge sys_clk_in);
    check(pin_value_out[2], 32'h0);
    $display("test blink done");
    rx_act_in <= 11'h001;
    @(posedge sys_clk_in);
    rx_act_in <= 11'h000;
    count_tog(3, 7, 16);
    check(t0 >= 3, 32'h1);
    tx_act_in <= 11'h001;
    @(posedge sys_clk_in);
    tx_act_in <= 11'h000;
    count_tog(3, 7, 16);
    check(t0 >= 3, 32'h1);
    count_tog(3, 7, 24);
    count_tog(3, 7, 16);
    check(t0, 32'h0);
    check(t1, 32'h4);
    rx_act_in <= 11'h002;
    @(posedge sys_clk_in);
    rx_act_in <= 11'h000;
    repeat (2) @(posedge sys_clk_in);
    count_tog(3, 7, 12);
    check(t0 + t1, 32'h0);
    $display("test activity done");
    wr(8'h80, 32'h0020_1881);
    repeat (2) @(posedge sys_clk_in);
    check(pin_value_out[1:0], 32'h2);
    pwm_src_in <= 3'h1;
    repeat (2) @(posedge sys_clk_in);
    check(pin_value_out[1:0], 32'h3);
    $display("test pwm done");
    print_verdict();
  end
endmodule
